// ===== hdl/wdcm_top.sv
// Watchdog, clock monitor, interrupt pin sense and top priority select with an AXI4-Lite slave.
// How it works
// - Edge-select 0 senses a low pin level; 1 senses falling edges only.
// - Stop-delay 1 inserts a stabilisation delay leaving stop; 0 resumes directly.
// - Monitor enabled: a slow or stopped clock raises a clock-failure reset.
// - Force-monitor 1 keeps the monitor enabled until next reset.
// - Rate codes 0..3 select timeouts of 2^15, 2^17, 2^19, 2^21 cycles.
// - Writing 55 hex to the service register arms the clearing mechanism.
// - Writing AA hex after arming restarts the watchdog count.
// - The service register reads zero always.
// - Priority select writes take effect only while the global mask is set.
// - The priority code promotes one maskable source above all others.
// - Unassigned priority codes behave as the external pin code.
// - Reset loads priority select with 06 hex; upper bits follow mode.
// - Boot, special and mode-A bits reset from straps, writable in special mode.
// - Maskable interrupts are taken only while the global mask is clear.
// - Normal mode: option bits other than monitor enable take one write within 64 cycles, then lock.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "wdcm_map.svh"
module wdcm_top (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clkEn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        irqPinN,
  input  wire logic        cpuTick,
  input  wire logic        globalMask,
  input  wire logic        stopRequest,
  input  wire logic [2:0]  modeStraps,
  input  wire logic        watchdogDisable,
  input  wire logic [22:0] maskableRequests,
  output logic             irqPinRequest,
  output logic             resumeGo,
  output logic [4:0]       promotedSource,
  output logic             takeInterrupt,
  output logic             watchdogFailReset,
  output logic             clockFailReset,
  output logic             intrOut
);
  localparam int EVN = 4;

  typedef struct packed {
    logic                    awDone;
    logic                    wDone;
    logic [11:0]             awAddr;
    logic [31:0]             wData;
    logic                    bValid;
    logic                    rValid;
    logic [31:0]             rData;
    logic [1:0]              rResp;
    logic [1:0]              bResp;
    wdcm_pkg::wdcm_opt_t     opt;
    logic                    optWritten;
    logic [6:0]              lockCnt;
    wdcm_pkg::wdcm_prio_t    prio;
    logic                    strapsTaken;
    logic                    armed;
    logic [20:0]             wdCnt;
    logic                    wdFail;
    logic [7:0]              tickGap;
    logic                    tickPrev;
    logic                    clkFail;
    logic                    pinPrev;
    logic                    pinLatch;
    wdcm_pkg::wdcm_pwr_t     pwr;
    logic [15:0]             dlyCnt;
    logic [EVN-1:0]          status;
    logic [EVN-1:0]          mask;
  } wdcm_state_t;

  wdcm_state_t st_q;
  wdcm_state_t st_d;
  logic [1:0]  pinsSync;
  logic        pinLow;
  logic        tickSync;
  logic        doWrite;
  logic [7:0]  wByte;
  logic        specialMode;
  logic        optOpen;
  logic        monitorOn;
  logic [20:0] wdLimit;
  logic [EVN-1:0] events;

  // Pin level and the external clock tick cross into the clock domain.
  // The pin is inverted first so that the synchroniser's reset value matches an idle pin and fakes no edge.
  wdcm_sync #(.W(2)) u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .en      (clkEn),
    .din     ({~irqPinN, cpuTick}),
    .dout    (pinsSync)
  );

  // Derived controls from the held state.
  always_comb begin
    pinLow      = pinsSync[1];
    tickSync    = pinsSync[0];
    doWrite     = st_q.awDone && st_q.wDone && !st_q.bValid;
    wByte       = st_q.wData[7:0];
    specialMode = st_q.prio.specialMode;
    optOpen     = specialMode || (!st_q.optWritten && st_q.lockCnt < `WDCM_LOCK_CYCLES);
    monitorOn   = st_q.opt.monitorEnable || st_q.opt.forceMonitor;
    wdLimit     = 21'((22'h008000 << (2 * st_q.opt.rateSelect)) - 22'h1);
    irqPinRequest = st_q.opt.edgeSelect ? st_q.pinLatch : pinLow;
    resumeGo    = (st_q.pwr == wdcm_pkg::WDCM_RUN);
    // Unassigned codes fall back to the external pin code.
    promotedSource = (st_q.prio.prioSelect < `WDCM_PRIO_FIRST || st_q.prio.prioSelect > `WDCM_PRIO_LAST)
                     ? `WDCM_PRIO_RESET : st_q.prio.prioSelect;
    takeInterrupt = !globalMask && ((|maskableRequests) || irqPinRequest);
    watchdogFailReset = st_q.wdFail;
    clockFailReset    = st_q.clkFail;
    intrOut     = |(st_q.status & st_q.mask);
  end

  // Next-state logic for the bus slave, option registers, watchdog and monitors.
  always_comb begin
    st_d = st_q;
    events = '0;
    if (s_axi_awvalid && !st_q.awDone) begin
      st_d.awDone = 1'b1;
      st_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.wDone) begin
      st_d.wDone = 1'b1;
      st_d.wData = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    end
    if (st_q.bValid && s_axi_bready) begin
      st_d.bValid = 1'b0;
    end
    if (st_q.rValid && s_axi_rready) begin
      st_d.rValid = 1'b0;
    end
    // Straps are caught once, in the first cycle after reset release.
    if (!st_q.strapsTaken) begin
      st_d.strapsTaken      = 1'b1;
      st_d.prio.bootRomRead = modeStraps[2];
      st_d.prio.specialMode = modeStraps[1];
      st_d.prio.modeSelectA = modeStraps[0];
    end
    if (st_q.lockCnt < `WDCM_LOCK_CYCLES) begin
      st_d.lockCnt = 7'(st_q.lockCnt + 7'h01);
    end
    // Watchdog counter runs unless disabled or already failed.
    if (!watchdogDisable && !st_q.wdFail) begin
      if (st_q.wdCnt >= wdLimit) begin
        st_d.wdFail = 1'b1;
        events[`WDCM_EV_WATCHDOG] = 1'b1;
      end else begin
        st_d.wdCnt = 21'(st_q.wdCnt + 21'h1);
      end
    end
    // Clock monitor: a long gap without a tick transition counts as a failure, whatever level the tick stops at.
    st_d.tickPrev = tickSync;
    if ((tickSync != st_q.tickPrev) || !monitorOn) begin
      st_d.tickGap = '0;
    end else if (st_q.tickGap == `WDCM_CLK_TIMEOUT && !st_q.clkFail) begin
      st_d.clkFail = 1'b1;
      events[`WDCM_EV_CLOCK] = 1'b1;
    end else if (st_q.tickGap != `WDCM_CLK_TIMEOUT) begin
      st_d.tickGap = 8'(st_q.tickGap + 8'h01);
    end
    // Falling edge capture on the interrupt pin, consumed when taken.
    st_d.pinPrev = pinLow;
    if (takeInterrupt) begin
      st_d.pinLatch = 1'b0;
    end
    if (pinLow && !st_q.pinPrev) begin
      st_d.pinLatch = 1'b1;
      events[`WDCM_EV_IRQPIN] = 1'b1;
    end
    // Stop entry and exit with optional stabilisation delay.
    unique case (st_q.pwr)
      wdcm_pkg::WDCM_RUN: begin
        if (stopRequest) begin
          st_d.pwr = wdcm_pkg::WDCM_STOP;
        end
      end
      wdcm_pkg::WDCM_STOP: begin
        if (!stopRequest) begin
          st_d.pwr    = st_q.opt.stopDelay ? wdcm_pkg::WDCM_DELAY : wdcm_pkg::WDCM_RUN;
          st_d.dlyCnt = '0;
        end
      end
      wdcm_pkg::WDCM_DELAY: begin
        if (st_q.dlyCnt == `WDCM_STOP_DELAY - 16'h1) begin
          st_d.pwr = wdcm_pkg::WDCM_RUN;
          events[`WDCM_EV_STOPDONE] = 1'b1;
        end else begin
          st_d.dlyCnt = 16'(st_q.dlyCnt + 16'h1);
        end
      end
      default: st_d.pwr = wdcm_pkg::WDCM_RUN;
    endcase
    // Register writes complete once address and data are both taken.
    if (doWrite) begin
      st_d.awDone = 1'b0;
      st_d.wDone  = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp  = 2'h0;
      unique case (st_q.awAddr)
        `WDCM_OFF_OPTIONS: begin
          if (optOpen) begin
            st_d.opt.edgeSelect = wByte[5];
            st_d.opt.stopDelay  = wByte[4];
            st_d.opt.forceMonitor = st_q.opt.forceMonitor | wByte[2];
            st_d.opt.rateSelect = wByte[1:0];
            st_d.optWritten     = 1'b1;
          end
          st_d.opt.monitorEnable = wByte[3];
        end
        `WDCM_OFF_SERVICE: begin
          if (wByte == `WDCM_PAT_ARM) begin
            st_d.armed = 1'b1;
          end else if (wByte == `WDCM_PAT_CLEAR && st_q.armed) begin
            st_d.armed = 1'b0;
            st_d.wdCnt = '0;
          end
        end
        `WDCM_OFF_PRIORITY: begin
          if (globalMask) begin
            st_d.prio.prioSelect = wByte[4:0];
          end
          if (specialMode) begin
            st_d.prio.bootRomRead = wByte[7];
            st_d.prio.specialMode = wByte[6];
            st_d.prio.modeSelectA = wByte[5];
          end
        end
        `WDCM_OFF_STATUS: st_d.status = st_q.status & ~wByte[EVN-1:0];
        `WDCM_OFF_MASK:   st_d.mask = wByte[EVN-1:0];
        default:          st_d.bResp = 2'h2;
      endcase
    end
    // Sticky status: a new event wins over a clear in the same cycle.
    st_d.status = st_d.status | events;
    // Register reads.
    if (s_axi_arvalid && !st_q.rValid) begin
      st_d.rValid = 1'b1;
      st_d.rResp  = 2'h0;
      st_d.rData  = '0;
      unique case (s_axi_araddr)
        `WDCM_OFF_OPTIONS:  st_d.rData[7:0] = {2'h0, st_q.opt.edgeSelect, st_q.opt.stopDelay,
                                               st_q.opt.monitorEnable, st_q.opt.forceMonitor,
                                               st_q.opt.rateSelect};
        `WDCM_OFF_SERVICE:  st_d.rData = '0;
        `WDCM_OFF_PRIORITY: st_d.rData[7:0] = st_q.prio;
        `WDCM_OFF_STATUS:   st_d.rData[EVN-1:0] = st_q.status;
        `WDCM_OFF_MASK:     st_d.rData[EVN-1:0] = st_q.mask;
        `WDCM_OFF_CONTROL:  st_d.rData[3:0] = {st_q.armed, st_q.optWritten, st_q.wdFail, st_q.clkFail};
        default:            st_d.rResp = 2'h2;
      endcase
    end
  end

  // Bus handshake outputs.
  always_comb begin
    s_axi_awready = !st_q.awDone;
    s_axi_wready  = !st_q.wDone;
    s_axi_bvalid  = st_q.bValid;
    s_axi_bresp   = st_q.bResp;
    s_axi_arready = !st_q.rValid;
    s_axi_rvalid  = st_q.rValid;
    s_axi_rdata   = st_q.rData;
    s_axi_rresp   = st_q.rResp;
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q                 <= '0;
      st_q.opt             <= wdcm_pkg::wdcm_opt_t'(6'(`WDCM_OPT_RESET));
      st_q.prio.prioSelect <= `WDCM_PRIO_RESET;
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end

  // An armed clearing write that is carried out before the watchdog has failed, whether or not it is disabled.
  sequence s_armedClear;
    clkEn && doWrite && st_q.awAddr == `WDCM_OFF_SERVICE && wByte == `WDCM_PAT_CLEAR && st_q.armed
    && !st_q.wdFail;
  endsequence

  property p_service;
    @(posedge ref_clk) disable iff (reset)
      s_armedClear |=> (st_q.wdCnt == 21'h0 || !clkEn);
  endproperty
  a_service: assert property (p_service) else $error("Armed clear did not restart the watchdog.");

  property p_noclear;
    @(posedge ref_clk) disable iff (reset)
      (clkEn && doWrite && st_q.awAddr == `WDCM_OFF_SERVICE && !st_q.armed && st_q.wdCnt > 21'h2
       && !watchdogDisable) |=> st_q.wdCnt != 21'h0;
  endproperty
  a_noclear: assert property (p_noclear) else $error("Unarmed write restarted the watchdog.");

  property p_prio;
    @(posedge ref_clk) disable iff (reset)
      (clkEn && doWrite && st_q.awAddr == `WDCM_OFF_PRIORITY && !globalMask) |=> $stable(st_q.prio.prioSelect);
  endproperty
  a_prio: assert property (p_prio) else $error("Priority changed with interrupts enabled.");

  property p_take;
    @(posedge ref_clk) disable iff (reset) globalMask |-> !takeInterrupt;
  endproperty
  a_take: assert property (p_take) else $error("Interrupt taken while masked.");

  property p_rsv;
    @(posedge ref_clk) disable iff (reset) (st_q.prio.prioSelect > 5'h14) |-> promotedSource == 5'h06;
  endproperty
  a_rsv: assert property (p_rsv) else $error("Reserved code not mapped to the pin.");

  property p_level;
    @(posedge ref_clk) disable iff (reset) !st_q.opt.edgeSelect |-> irqPinRequest == pinLow;
  endproperty
  a_level: assert property (p_level) else $error("Level sense mismatch.");

  property p_lock;
    @(posedge ref_clk) disable iff (reset)
      (clkEn && !specialMode && st_q.optWritten) |=> $stable(st_q.opt.rateSelect);
  endproperty
  a_lock: assert property (p_lock) else $error("Option bits changed after lock.");

  property p_force;
    @(posedge ref_clk) disable iff (reset) st_q.opt.forceMonitor |=> st_q.opt.forceMonitor;
  endproperty
  a_force: assert property (p_force) else $error("Force monitor cleared before reset.");

  property p_wdfail;
    @(posedge ref_clk) disable iff (reset)
      (clkEn && !watchdogDisable && !st_q.wdFail && st_q.wdCnt >= wdLimit) |=> watchdogFailReset;
  endproperty
  a_wdfail: assert property (p_wdfail) else $error("Watchdog timeout did not raise failure.");
endmodule : wdcm_top

// ===== hdl/wdcm_map.svh
// Register offsets, field positions, reset values and timing counts of the watchdog and clock monitor block.
`ifndef WDCM_MAP_SVH
`define WDCM_MAP_SVH
`define WDCM_OFF_OPTIONS    12'h000
`define WDCM_OFF_SERVICE    12'h004
`define WDCM_OFF_PRIORITY   12'h008
`define WDCM_OFF_STATUS     12'h00C
`define WDCM_OFF_MASK       12'h010
`define WDCM_OFF_CONTROL    12'h014
`define WDCM_OPT_RESET      8'h10
`define WDCM_PRIO_RESET     5'h06
`define WDCM_PAT_ARM        8'h55
`define WDCM_PAT_CLEAR      8'hAA
`define WDCM_LOCK_CYCLES    7'h40
`define WDCM_STOP_DELAY     16'h1000
`define WDCM_CLK_TIMEOUT    8'h20
`define WDCM_PRIO_FIRST     5'h06
`define WDCM_PRIO_LAST      5'h14
`define WDCM_EV_WATCHDOG    0
`define WDCM_EV_CLOCK       1
`define WDCM_EV_STOPDONE    2
`define WDCM_EV_IRQPIN      3
`endif

// ===== hdl/wdcm_pkg.sv
// Types shared by the watchdog and clock monitor block.
package wdcm_pkg;
  typedef enum logic [1:0] {
    WDCM_RUN   = 2'h0,
    WDCM_STOP  = 2'h1,
    WDCM_DELAY = 2'h3
  } wdcm_pwr_t;

  typedef struct packed {
    logic       edgeSelect;
    logic       stopDelay;
    logic       monitorEnable;
    logic       forceMonitor;
    logic [1:0] rateSelect;
  } wdcm_opt_t;

  typedef struct packed {
    logic       bootRomRead;
    logic       specialMode;
    logic       modeSelectA;
    logic [4:0] prioSelect;
  } wdcm_prio_t;
endpackage : wdcm_pkg

// ===== hdl/wdcm_sync.sv
// Two-flip-flop synchroniser for the asynchronous pins of the block.
`timescale 1ns/1ps
module wdcm_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic         en,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // The first stage only feeds the second stage; both hold while the clock enable is low.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_q <= '0;
      dout   <= '0;
    end else if (en) begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : wdcm_sync

// ===== sim/tb_top.sv
// Self-checking testbench of the watchdog, clock monitor and priority select block.
`timescale 1ns/1ps
`include "wdcm_map.svh"
module tb_top;
  localparam int LIMIT = 90000;
  logic        ref_clk = 1'b0, reset = 1'b1, clkEn = 1'b1, cpuTick = 1'b0, tickRun = 1'b1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, irqPinN = 1'b1, globalMask = 1'b1;
  logic        stopRequest = 1'b0, watchdogDisable = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0]  modeStraps = 3'h0;
  logic [22:0] maskableRequests = 23'h0;
  logic [4:0]  promotedSource;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        irqPinRequest, resumeGo, takeInterrupt, watchdogFailReset, clockFailReset, intrOut;
  int          err_total = 0, checked = 0, cycles = 0, n, i;
  logic [4:0]  rowCode [14] = '{5'h00, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0A, 5'h10, 5'h13, 5'h14, 5'h15,
                                5'h17, 5'h18, 5'h1F};
  logic [4:0]  rowExp  [14] = '{5'h06, 5'h06, 5'h06, 5'h06, 5'h06, 5'h07, 5'h0A, 5'h10, 5'h13, 5'h14, 5'h06,
                                5'h06, 5'h06, 5'h06};

  wdcm_top u_dut (
    .ref_clk, .reset, .clkEn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irqPinN, .cpuTick, .globalMask,
    .stopRequest, .modeStraps, .watchdogDisable, .maskableRequests, .irqPinRequest, .resumeGo, .promotedSource,
    .takeInterrupt, .watchdogFailReset, .clockFailReset, .intrOut
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("Comparisons: %0d, mismatches: %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // Counts a comparison and reports a mismatch.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Waits a number of rising edges.
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : tick

  // One bus write; address and data are released as each is taken, bready stays high between transfers.
  task automatic axiWrite(input logic [11:0] a, input logic [31:0] d);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge ref_clk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    rsp = s_axi_bresp;
    check(k < 100, 1'b1);
  endtask : axiWrite

  // One bus read; data and response are taken at the edge that shows rvalid.
  task automatic axiRead(input logic [11:0] a);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge ref_clk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    check(k < 100, 1'b1);
  endtask : axiRead

  // Reads a register and compares it.
  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
    axiRead(a);
    check(rd, exp);
  endtask : rdChk

  // Holds reset for 20 cycles with the given mode straps.
  task automatic doReset(input logic [2:0] s);
    reset <= 1'b1;
    modeStraps <= s;
    tick(20);
    reset <= 1'b0;
    tick(1);
  endtask : doReset

  // Free-running clock.
  always #5 ref_clk = ~ref_clk;

  // Clock-activity tick toggles while enabled.
  always @(posedge ref_clk) begin
    if (tickRun) cpuTick <= ~cpuTick;
  end

  // Cuts a hung run short.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_total = err_total + 1;
      wrap_up();
    end
  end

  // Main sequence: normal mode first, then special mode, then the watchdog.
  initial begin
    doReset(3'h0);
    check(irqPinRequest, 1'b0);
    rdChk(`WDCM_OFF_OPTIONS, `WDCM_OPT_RESET);
    rdChk(`WDCM_OFF_PRIORITY, 32'h06);
    axiWrite(`WDCM_OFF_SERVICE, `WDCM_PAT_ARM);
    rdChk(`WDCM_OFF_SERVICE, 32'h0);
    axiRead(12'h020);
    check(rsp, 2'h2);
    axiWrite(`WDCM_OFF_OPTIONS, 32'h21);
    rdChk(`WDCM_OFF_OPTIONS, 32'h21);
    axiWrite(`WDCM_OFF_OPTIONS, 32'h12);
    rdChk(`WDCM_OFF_OPTIONS, 32'h21);
    check(irqPinRequest, 1'b0);
    axiWrite(`WDCM_OFF_PRIORITY, 32'hE7);
    rdChk(`WDCM_OFF_PRIORITY, 32'h07);
    irqPinN <= 1'b0;
    tick(6);
    check(irqPinRequest, 1'b1);
    check(takeInterrupt, 1'b0);
    globalMask <= 1'b0;
    tick(6);
    check(irqPinRequest, 1'b0);
    irqPinN <= 1'b1;
    globalMask <= 1'b1;
    doReset(3'h0);
    tick(`WDCM_LOCK_CYCLES);
    axiWrite(`WDCM_OFF_OPTIONS, 32'h21);
    rdChk(`WDCM_OFF_OPTIONS, `WDCM_OPT_RESET);
    irqPinN <= 1'b0;
    tick(6);
    check(irqPinRequest, 1'b1);
    irqPinN <= 1'b1;
    tick(6);
    check(irqPinRequest, 1'b0);
    stopRequest <= 1'b1;
    tick(4);
    check(resumeGo, 1'b0);
    stopRequest <= 1'b0;
    for (n = 0; n < 5000 && resumeGo !== 1'b1; n++) tick(1);
    check(n >= `WDCM_STOP_DELAY && n < 5000, 1'b1);
    axiRead(`WDCM_OFF_STATUS);
    check(rd[`WDCM_EV_STOPDONE], 1'b1);
    check(intrOut, 1'b0);
    axiWrite(`WDCM_OFF_MASK, 32'h4);
    tick(2);
    check(intrOut, 1'b1);
    axiWrite(`WDCM_OFF_STATUS, 32'h4);
    tick(2);
    check(intrOut, 1'b0);
    axiWrite(12'h020, 32'h1);
    check(rsp, 2'h2);
    doReset(3'h2);
    rdChk(`WDCM_OFF_PRIORITY, 32'h46);
    axiWrite(`WDCM_OFF_PRIORITY, 32'hE7);
    rdChk(`WDCM_OFF_PRIORITY, 32'hE7);
    for (i = 0; i < 14; i++) begin
      axiWrite(`WDCM_OFF_PRIORITY, {27'h7, rowCode[i]});
      check(promotedSource, rowExp[i]);
    end
    globalMask <= 1'b0;
    axiWrite(`WDCM_OFF_PRIORITY, 32'hEA);
    check(promotedSource, 5'h06);
    maskableRequests <= 23'h1;
    tick(2);
    check(takeInterrupt, 1'b1);
    globalMask <= 1'b1;
    tick(2);
    check(takeInterrupt, 1'b0);
    maskableRequests <= 23'h0;
    axiWrite(`WDCM_OFF_OPTIONS, 32'h08);
    rdChk(`WDCM_OFF_OPTIONS, 32'h08);
    stopRequest <= 1'b1;
    tick(4);
    stopRequest <= 1'b0;
    for (n = 0; n < 20 && resumeGo !== 1'b1; n++) tick(1);
    check(n < 20, 1'b1);
    tick(100);
    check(clockFailReset, 1'b0);
    clkEn <= 1'b0;
    tickRun <= 1'b0;
    tick(80);
    check(clockFailReset, 1'b0);
    clkEn <= 1'b1;
    for (n = 0; n < 80 && clockFailReset !== 1'b1; n++) tick(1);
    check(n > 28 && n < 80, 1'b1);
    doReset(3'h2);
    tick(80);
    check(clockFailReset, 1'b0);
    tickRun <= 1'b1;
    axiWrite(`WDCM_OFF_OPTIONS, 32'h04);
    axiWrite(`WDCM_OFF_OPTIONS, 32'h00);
    rdChk(`WDCM_OFF_OPTIONS, 32'h04);
    tickRun <= 1'b0;
    for (n = 0; n < 80 && clockFailReset !== 1'b1; n++) tick(1);
    check(n < 80, 1'b1);
    doReset(3'h0);
    tickRun <= 1'b1;
    watchdogDisable <= 1'b0;
    tick(30000);
    check(watchdogFailReset, 1'b0);
    axiWrite(`WDCM_OFF_SERVICE, `WDCM_PAT_ARM);
    axiWrite(`WDCM_OFF_SERVICE, `WDCM_PAT_CLEAR);
    tick(16000);
    axiWrite(`WDCM_OFF_SERVICE, `WDCM_PAT_CLEAR);
    tick(16000);
    check(watchdogFailReset, 1'b0);
    for (n = 0; n < 1500 && watchdogFailReset !== 1'b1; n++) tick(1);
    check(n < 1500, 1'b1);
    wrap_up();
  end
endmodule : tb_top
